// ---- dds_top.sv ----
// Contract
// - converter updates every 20 us by hardware tick
// - steps through sixteen dither states autonomously
// - one tick loads buffer and updates output
// - reload event every sixteen transfers rearms sequence
// - tick period from clock; transfer takes eight cycles
// - adder zero gives base, one gives base+1
// - factor N yields N ones per sixteen states
// - factors 0, 7, 15 give 0, 7, 15 ones
// - adder bits from fixed sixteen by sixteen table
// - factor seven pattern is fixed sequence, alternating except at two double zeros
// - target is base high, factor low nibble
// - monitor conversions triggered at 16384 Hz from subclock
// - flag each conversion, sum every sixteen
// - closed loop corrects pattern from measured value
// - serial port reports sums as ASCII at 115.2k
// - every 256 samples target steps +1, -1 or holds
`timescale 1ns/100ps
`include "dds_cfg.svh"

module dds_top
  import dds_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // requested output level and modes
  input wire logic [7:0] base_code,
  input wire logic [3:0] dither_factor,
  input wire logic monitor_enable,
  input wire logic loop_enable,
  // converter side
  output logic [7:0] dac_code,
  output logic dac_latch,
  output logic seq_reload,
  output logic [11:0] active_target,
  // monitoring converter
  input wire logic sub_clock,
  input wire logic adc_done,
  input wire logic [9:0] adc_result,
  output logic adc_start,
  output logic conv_done,
  output logic sum_valid,
  output logic [13:0] sum,
  // serial monitor port
  input wire logic serial_cts,
  output logic serial_tx
);

  // adder columns, one per factor; bit s is dither state s+1
  localparam logic [15:0] pattern [16] = '{
    16'h0000, 16'h0001, 16'h0101, 16'h0421,
    16'h1111, 16'h1249, 16'h2525, 16'h2a55,
    16'h5555, 16'hd5aa, 16'hdada, 16'hedb6,
    16'heeee, 16'hfbde, 16'hfefe, 16'hfffe
  };

  // dither path state
  logic [15:0] tick_count;
  logic [3:0] xfer_count;
  logic [3:0] dither_state;
  logic [7:0] dac_code_buffer;
  // monitoring and loop state
  logic sub_prev;
  logic [1:0] sub_div;
  logic [13:0] acc;
  logic [3:0] conv_count;
  logic [3:0] sum_count;
  logic sum_hold;
  dds_target_type loop_target;
  // fifo between sums and serial port
  logic [13:0] fifo_mem [2];
  logic fifo_wr;
  logic fifo_rd;
  logic [1:0] fifo_count;
  // serial transmitter
  dds_tx_state_type tx_state;
  logic [7:0] baud_count;
  logic [2:0] bit_idx;
  logic [2:0] char_idx;
  logic [7:0] tx_shift;
  logic [13:0] tx_word;

  // tick and transfer decode
  wire tick_hit = tick_count == 16'(`DDS_TICK_CYCLES - 1);
  wire wrap = dither_state == `DDS_LAST_STATE;
  wire [3:0] next_state = dither_state + 4'h1;
  wire xfer_done = xfer_count == 4'h1;

  // requested target, clamped so base+1 never overflows
  wire [11:0] req_raw = {base_code, dither_factor};
  wire [11:0] req_open = (req_raw > `DDS_TARGET_MAX) ? `DDS_TARGET_MAX : req_raw;
  wire [11:0] req_target = loop_enable ? loop_target : req_open;

  // code for the state now being transferred into the buffer
  wire [7:0] act_base = active_target[11:4];
  wire [3:0] act_factor = active_target[3:0];
  wire [15:0] act_pattern = pattern[act_factor];
  wire adder_bit = act_pattern[dither_state];
  wire [7:0] next_code = act_base + {7'h00, adder_bit};

  // monitoring decode
  wire sub_rise = sub_clock & ~sub_prev;
  wire trig_hit = sub_rise && (sub_div == 2'(`DDS_SUB_DIV - 1));
  wire conv_take = adc_done && !sum_hold;
  wire conv_last = conv_count == `DDS_LAST_CONV;
  wire [13:0] next_sum = acc + {4'h0, adc_result};
  wire loop_step = conv_take && conv_last && (sum_count == `DDS_LAST_SUM);
  wire [11:0] measured = next_sum[13:2];

  // fifo decode
  wire fifo_full = fifo_count == 2'd2;
  wire fifo_push = sum_hold && !fifo_full;
  wire [13:0] fifo_head = fifo_mem[fifo_rd];

  // serial decode
  wire baud_hit = baud_count == 8'(`DDS_BAUD_CYCLES - 1);
  wire tx_begin = (tx_state == TX_IDLE) && (fifo_count != 2'd0) && serial_cts;
  wire fifo_pop = tx_begin;
  wire [15:0] tx_hex = {2'b00, tx_word};
  wire [3:0] nib_sel = 4'd12 - {char_idx[1:0], 2'b00};
  wire [3:0] nibble = tx_hex[nib_sel +: 4];
  wire [7:0] hex_char = (nibble < 4'ha) ? (8'h30 + {4'h0, nibble}) : (8'h37 + {4'h0, nibble});
  wire [7:0] next_char = (char_idx == `DDS_LAST_CHAR) ? `DDS_CHAR_CR : hex_char;

  // free running 16-bit tick timer, no software in the path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_count <= 16'h0000;
    end else if (tick_hit) begin
      tick_count <= 16'h0000;
    end else begin
      tick_count <= tick_count + 16'h0001;
    end
  end

  // one tick latches the converter and starts the next buffer load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_code <= `DDS_RESET_CODE;
      dac_latch <= 1'b0;
      seq_reload <= 1'b0;
      dither_state <= `DDS_LAST_STATE;
      xfer_count <= 4'h0;
    end else begin
      dac_latch <= tick_hit;
      seq_reload <= tick_hit && wrap;
      if (tick_hit) begin
        dac_code <= dac_code_buffer;
        dither_state <= next_state;
        xfer_count <= 4'(`DDS_XFER_CYCLES);
      end else if (xfer_count != 4'h0) begin
        xfer_count <= xfer_count - 4'h1;
      end
    end
  end

  // target changes only where the sequence wraps back to state one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_target <= `DDS_RESET_TARGET;
    end else if (tick_hit && wrap) begin
      active_target <= req_target;
    end
  end

  // buffer load lands when the transfer finishes, long before the next tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_code_buffer <= `DDS_RESET_CODE;
    end else if (xfer_done) begin
      dac_code_buffer <= next_code;
    end
  end

  // sub clock arrives synchronous; divide its rising edges for triggers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_prev <= 1'b0;
      sub_div <= 2'b00;
      adc_start <= 1'b0;
    end else begin
      sub_prev <= sub_clock;
      if (trig_hit) begin
        sub_div <= 2'b00;
      end else if (sub_rise) begin
        sub_div <= sub_div + 2'b01;
      end
      adc_start <= trig_hit && monitor_enable;
    end
  end

  // sum sixteen conversions; while a sum waits for the fifo, samples are skipped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= 14'h0000;
      conv_count <= 4'h0;
      sum_count <= 4'h0;
      sum <= 14'h0000;
      sum_valid <= 1'b0;
      sum_hold <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= adc_done;
      sum_valid <= conv_take && conv_last;
      if (conv_take) begin
        conv_count <= conv_count + 4'h1;
        acc <= conv_last ? 14'h0000 : next_sum;
        if (conv_last) begin
          sum <= next_sum;
          sum_count <= sum_count + 4'h1;
        end
      end
      // a new sum cannot arrive while one is held, so set and clear never meet
      if (conv_take && conv_last) begin
        sum_hold <= 1'b1;
      end else if (fifo_push) begin
        sum_hold <= 1'b0;
      end
    end
  end

  // bang-bang correction on the twelve-bit value, with carry and saturation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_target <= `DDS_RESET_TARGET;
    end else if (!loop_enable) begin
      loop_target <= req_open;
    end else if (loop_step) begin
      if ((measured < req_open) && (loop_target < `DDS_TARGET_MAX)) begin
        loop_target <= loop_target + 12'h001;
      end else if ((measured > req_open) && (loop_target != 12'h000)) begin
        loop_target <= loop_target - 12'h001;
      end
    end
  end

  // two-entry fifo; a stalled serial port backs up into the summer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fifo_wr <= 1'b0;
      fifo_rd <= 1'b0;
      fifo_count <= 2'd0;
      fifo_mem[0] <= 14'h0000;
      fifo_mem[1] <= 14'h0000;
    end else begin
      if (fifo_push) begin
        fifo_mem[fifo_wr] <= sum;
        fifo_wr <= ~fifo_wr;
      end
      if (fifo_pop) begin
        fifo_rd <= ~fifo_rd;
      end
      fifo_count <= fifo_count + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // serial transmitter: four hex digits and a carriage return per sum
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      baud_count <= 8'h00;
      bit_idx <= 3'h0;
      char_idx <= 3'h0;
      tx_shift <= 8'h00;
      tx_word <= 14'h0000;
      serial_tx <= 1'b1;
    end else begin
      baud_count <= (tx_state == TX_IDLE || baud_hit) ? 8'h00 : baud_count + 8'h01;
      case (tx_state)
        TX_IDLE: begin
          serial_tx <= 1'b1;
          char_idx <= 3'h0;
          if (tx_begin) begin
            tx_word <= fifo_head;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          serial_tx <= 1'b0;
          tx_shift <= next_char;
          bit_idx <= 3'h0;
          if (baud_hit) begin
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          serial_tx <= tx_shift[bit_idx];
          if (baud_hit) begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              tx_state <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          serial_tx <= 1'b1;
          if (baud_hit) begin
            if (char_idx == `DDS_LAST_CHAR) begin
              tx_state <= TX_IDLE;
            end else begin
              char_idx <= char_idx + 3'h1;
              tx_state <= TX_START;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

endmodule : dds_top

// ---- dds_cfg.svh ----
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH

// system clock and the dither tick period
`define DDS_CLK_HZ 25000000
`define DDS_TICK_NS 20000
`define DDS_TICK_CYCLES ((`DDS_TICK_NS * (`DDS_CLK_HZ / 1000000)) / 1000)
// cycles the buffer load transfer takes after each tick
`define DDS_XFER_CYCLES 8
// dither sequence length and last state index
`define DDS_LAST_STATE 4'hf
// sub clock to monitoring trigger divider (32768 Hz down to 16384 Hz)
`define DDS_SUB_HZ 32768
`define DDS_TRIG_HZ 16384
`define DDS_SUB_DIV (`DDS_SUB_HZ / `DDS_TRIG_HZ)
// conversions per sum, and sums per loop step (16 x 16 = 256 samples)
`define DDS_LAST_CONV 4'hf
`define DDS_LAST_SUM 4'hf
// serial monitor port
`define DDS_BAUD 115200
`define DDS_BAUD_CYCLES (`DDS_CLK_HZ / `DDS_BAUD)
`define DDS_LAST_CHAR 3'h4
`define DDS_CHAR_CR 8'h0d
// highest target that keeps base plus one inside eight bits
`define DDS_TARGET_MAX 12'hff0
// reset values
`define DDS_RESET_CODE 8'h00
`define DDS_RESET_TARGET 12'h000

`endif

// ---- dds_pkg.sv ----
package dds_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } dds_tx_state_type;

  typedef logic [11:0] dds_target_type;

endpackage : dds_pkg

// ---- dds_properties.sv ----
`timescale 1ns/100ps
module dds_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // converter side
  input wire logic [7:0] dac_code,
  input wire logic dac_latch,
  input wire logic seq_reload,
  input wire logic [11:0] active_target,
  // monitoring
  input wire logic adc_done,
  input wire logic adc_start,
  input wire logic conv_done,
  input wire logic sum_valid
);
  logic [9:0] gap;
  logic [4:0] run;
  logic gap_ok;
  logic run_ok;
  // gap saturates so a lost tick cannot wrap back to a legal count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 10'h000;
      run <= 5'h00;
      gap_ok <= 1'b0;
      run_ok <= 1'b0;
    end else begin
      gap <= dac_latch ? 10'h001 : gap + {9'h000, gap != 10'h3ff};
      run <= seq_reload ? 5'h01 : run + {4'h0, dac_latch};
      gap_ok <= gap_ok | dac_latch;
      run_ok <= run_ok | seq_reload;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence quiet_starts;
    !adc_start [*8];
  endsequence
  sequence sum_closes;
    conv_done ##1 !sum_valid;
  endsequence
  AST_TICK_PERIOD: assert property (dac_latch && gap_ok |-> gap == 10'h1f4)
    else $error("tick spacing wrong");
  AST_CODE_HOLD: assert property (!dac_latch |-> $stable(dac_code))
    else $error("code moved without latch");
  AST_RELOAD_ON_TICK: assert property (seq_reload |-> dac_latch)
    else $error("reload off tick");
  AST_RELOAD_EVERY_16: assert property (seq_reload && run_ok |-> run == 5'h10)
    else $error("reload count wrong");
  AST_TARGET_AT_WRAP: assert property (!seq_reload |-> $stable(active_target))
    else $error("target changed mid sequence");
  AST_CODE_BASE_OR_NEXT: assert property (dac_latch && !seq_reload |->
    dac_code == active_target[11:4] || (active_target[3:0] != 4'h0 &&
    dac_code == active_target[11:4] + 8'h01)) else $error("code off target");
  AST_TARGET_CLAMP: assert property (active_target <= 12'hff0)
    else $error("target above limit");
  AST_CONV_FLAG: assert property (conv_done |-> $past(adc_done))
    else $error("conv flag without done");
  AST_SUM_PULSE: assert property (sum_valid |-> sum_closes)
    else $error("sum pulse wrong");
  AST_START_SPACING: assert property (adc_start |=> quiet_starts)
    else $error("starts too close");
endmodule : dds_properties

bind dds_top dds_properties u_props (.clk(clk), .resetn(resetn), .dac_code(dac_code),
  .dac_latch(dac_latch), .seq_reload(seq_reload), .active_target(active_target),
  .adc_done(adc_done), .adc_start(adc_start), .conv_done(conv_done), .sum_valid(sum_valid));

// ---- dds_far_model.sv ----
`timescale 1ns/100ps
module dds_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // converter
  input wire logic [7:0] dac_code,
  input wire logic dac_latch,
  output logic [7:0] dac_level,
  // monitoring converter
  input wire logic adc_start,
  output logic adc_done,
  output logic [9:0] adc_result
);
  logic [5:0] busy;
  logic slow;
  // analog level follows only the latch strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) dac_level <= 8'h00;
    else if (dac_latch) dac_level <= dac_code;
  end
  // answers alternate fast and slow; result is junk outside the done cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 6'h00;
      slow <= 1'b0;
      adc_done <= 1'b0;
      adc_result <= 10'h3ff;
    end else begin
      adc_done <= busy == 6'h01;
      adc_result <= (busy == 6'h01) ? 10'h2a5 : ~adc_result;
      if (adc_start) begin
        busy <= slow ? 6'h28 : 6'h02;
        slow <= ~slow;
      end else if (busy != 6'h00) busy <= busy - 6'h01;
    end
  end
endmodule : dds_far_model

// ---- test_dac_dither_sequencer.sv ----
`timescale 1ns/100ps
module test_dac_dither_sequencer;
  localparam logic [15:0] PAT [16] = '{16'h0000, 16'h0001, 16'h0101, 16'h0421, 16'h1111,
    16'h1249, 16'h2525, 16'h2a55, 16'h5555, 16'hd5aa, 16'hdada, 16'hedb6, 16'heeee,
    16'hfbde, 16'hfefe, 16'hfffe};
  localparam logic [15:0] SUM = {2'b00, 10'h2a5, 4'h0};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] base_code = 8'h80;
  logic [3:0] dither_factor = 4'h7;
  logic monitor_enable = 1'b0;
  logic sub_clock = 1'b0;
  logic [7:0] dac_code, dac_level, ch;
  logic [11:0] active_target;
  logic [13:0] sum;
  logic [9:0] adc_result;
  logic dac_latch, seq_reload, adc_start, adc_done, conv_done, sum_valid, serial_tx;
  int n_errors = 0;
  int n_compared = 0;
  dds_top DUT (.clk(clk), .resetn(resetn), .base_code(base_code),
    .dither_factor(dither_factor), .monitor_enable(monitor_enable), .loop_enable(1'b0),
    .dac_code(dac_code), .dac_latch(dac_latch), .seq_reload(seq_reload),
    .active_target(active_target), .sub_clock(sub_clock), .adc_done(adc_done),
    .adc_result(adc_result), .adc_start(adc_start), .conv_done(conv_done),
    .sum_valid(sum_valid), .sum(sum), .serial_cts(1'b1), .serial_tx(serial_tx));
  dds_far_model u_far (.clk(clk), .resetn(resetn), .dac_code(dac_code),
    .dac_latch(dac_latch), .dac_level(dac_level), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result(adc_result));
  initial forever #20 clk = ~clk;
  // sub clock kept synchronous, 762 cycles a period
  initial forever begin
    repeat (381) @(posedge clk);
    sub_clock <= ~sub_clock;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_on(input int lim, ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sig !== 1'b1 && n < lim);
  endtask : wait_on
  // one sequence of 16 ticks; the next request lands mid sequence and must wait
  task dither_seq(input logic [11:0] req, input logic [11:0] nxt);
    logic [11:0] t;
    t = (req > 12'hff0) ? 12'hff0 : req;
    chk(16'(active_target), 16'(t), "target");
    @(posedge clk);
    {base_code, dither_factor} <= nxt;
    for (int k = 0; k < 16; k++) begin
      wait_on(600, dac_latch);
      chk(16'(dac_code), 16'(t[11:4] + PAT[t[3:0]][k]), "code");
      chk(16'(seq_reload), 16'(k == 15), "reload");
    end
    $display("test dither %h done", t);
  endtask : dither_seq
  task dither_all;
    wait_on(600, dac_latch);
    chk(16'(dac_code), 16'h0000, "first code");
    dither_seq(12'h807, 12'h4a8);
    dither_seq(12'h4a8, 12'h120);
    dither_seq(12'h120, 12'hfff);
    dither_seq(12'hfff, 12'h3cf);
    dither_seq(12'h3cf, 12'h3cf);
  endtask : dither_all
  // sixteen conversions make one sum, then the serial group reports it
  task monitor_test;
    int convs;
    convs = 0;
    @(posedge clk);
    monitor_enable <= 1'b1;
    for (int n = 0; n < 40000 && sum_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      convs += int'(conv_done === 1'b1);
    end
    chk(16'(convs), 16'h0010, "conversions");
    chk(16'(sum), SUM, "sum");
    for (int i = 0; i < 5; i++) begin
      // the line itself must be watched; a copy taken once would never fall
      for (int w = 0; w < 30000 && serial_tx !== 1'b0; w++) begin
        @(posedge clk);
        #1;
      end
      repeat (108) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
        repeat (217) @(posedge clk);
        ch[b] = serial_tx;
      end
      repeat (217) @(posedge clk);
      chk(16'(serial_tx), 16'h0001, "stop");
      chk(16'(ch), 16'(i == 4 ? 8'h0d : (SUM[15 - 4 * i -: 4] < 4'ha ? 8'h30 : 8'h37)
        + SUM[15 - 4 * i -: 4]), "char");
    end
    $display("test monitor done");
  endtask : monitor_test
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    fork
      dither_all;
      monitor_test;
    join
    report_and_stop;
  end
  // the longer thread needs about 41000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    $display("FAIL %0t watchdog", $time);
    report_and_stop;
  end
endmodule : test_dac_dither_sequencer
